// ### design/disk_host_pkg.sv
/*
  Constants shared by the disk controller host port: device codes, bit
  positions of the accumulator fields, mask-out bit, reset values and command codes.
  Assumes bit 0 of every bus word is the most significant bit, as on the host bus.
*/
package disk_host_pkg;

  // device codes (octal 33 and 73) for the primary and the second controller
  localparam logic [5:0] DEV_CODE_PRIMARY   = 6'h1B;
  localparam logic [5:0] DEV_CODE_SECONDARY = 6'h3B;

  // command field of cylinder_and_command
  localparam logic [1:0] CMD_READ  = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_SEEK  = 2'h2;
  localparam logic [1:0] CMD_RECALIBRATE_CMD = 2'h3;

  // data-out-a clear bits and cylinder/command field start (bus numbering, bit 0 most significant)
  localparam int CLR_ERR_DONE_BIT = 0;
  localparam int CLR_SEEK_LO_BIT  = 1;
  localparam int CYL_CMD_LO_BIT   = 6;

  // data-out-c field positions
  localparam int DOC_FORMAT_BIT = 0;
  localparam int DOC_UNIT_LO    = 1;
  localparam int DOC_HEAD_BIT   = 3;
  localparam int DOC_SECTOR_LO  = 4;
  localparam int DOC_COUNT_LO   = 8;

  // mask-out bit that disables the interrupt request (bus numbering)
  localparam int MASK_DISABLE_BIT = 7;

  // reset values
  localparam logic [9:0]  CYL_CMD_RESET = 10'h000;
  localparam logic [15:0] REG_RESET     = 16'h0000;

endpackage : disk_host_pkg

// ### design/cmd_decode.sv
/*
  Command decoder: turns the two command bits into one active-low line.
  Assumes the caller registers the outputs; this module is purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module cmd_decode (
  // command bits
  input  wire logic command_bit_high,
  input  wire logic command_bit_low,
  // one-cold decoded lines
  output logic      recalibrate_cmd_n,
  output logic      seek_cmd_n,
  output logic      read_cmd_n,
  output logic      write_cmd_n
);
  import disk_host_pkg::*;

  // exactly one line low for every code
  always_comb begin
    recalibrate_cmd_n = 1'b1;
    seek_cmd_n        = 1'b1;
    read_cmd_n        = 1'b1;
    write_cmd_n       = 1'b1;
    unique case ({command_bit_high, command_bit_low})
      CMD_READ:  read_cmd_n        = 1'b0;
      CMD_WRITE: write_cmd_n       = 1'b0;
      CMD_SEEK:  seek_cmd_n        = 1'b0;
      CMD_RECALIBRATE_CMD: recalibrate_cmd_n = 1'b0;
    endcase
  end

endmodule : cmd_decode
`default_nettype wire

// ### design/disk_ctrl_host_io_port.sv
/*
  Host I/O port of a moving head disk controller: decodes bus instructions,
  holds unit/head/sector/count and cylinder/command registers, answers reads,
  raises interrupts and requests the disk adapter through a start line.
  Assumes every bus pin and adapter line is asynchronous to mclk and is held
  for several clocks per instruction; each is synchronised by two flip-flops.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// - only instructions carrying our wired device code are obeyed, except mask-out and acknowledge
// - code match opens instruction gating and busy/done flag outputs
// - data-out-c loads count, sector, head, format and unit from the bus
// - data-in-a puts the 16-bit status word on the bus
// - data-in-c puts unit, head, sector and count on the bus
// - bus drivers off unless one of four read conditions is active
// - data-out-a loads 10 bits: command on top, cylinder below
// - command bits decode to one low line; 10 seek, 01 write
// - top five data-out-a bits clear error, done and seek-complete flags
// - selected pulse sets start flop driving the low start request
// - data-out-b loads core address; function 01 raises start
// - mask-out bit 7 set disables interrupt request, clear enables
// - seek done raises request; acknowledge with priority returns device code
// - grant fires start-adapter pulse and resets the start flop on the same edge
module disk_ctrl_host_io_port #(
  parameter logic [5:0] DEVICE_CODE = disk_host_pkg::DEV_CODE_PRIMARY,
  parameter int         UNITS       = 4
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            reset_n,
  // host instruction bus
  input  wire logic [5:0]      device_code_in,
  input  wire logic            data_out_a,
  input  wire logic            data_out_b,
  input  wire logic            data_out_c,
  input  wire logic            data_in_a,
  input  wire logic            data_in_b,
  input  wire logic            data_in_c,
  input  wire logic            pulse_function,
  input  wire logic            start_function,
  input  wire logic            mask_out,
  input  wire logic            interrupt_acknowledge,
  input  wire logic            priority_chain_in,
  // host data bus, bit 0 most significant
  input  wire logic [0:15]     data_bus_in,
  output logic      [0:15]     data_bus_out,
  output logic      [0:15]     data_bus_oe,
  // flags toward the host
  output logic                 busy_flag_out,
  output logic                 done_flag_out,
  output logic                 interrupt_request_line,
  output logic                 priority_chain_out,
  // adapter and drive side
  input  wire logic            adapter_selected,
  input  wire logic [UNITS-1:0] seek_done_in,
  input  wire logic            drive_ready,
  input  wire logic            error_event,
  input  wire logic            done_event,
  output logic                 start_request_n,
  output logic                 start_adapter_pulse,
  output logic                 recalibrate_cmd_n,
  output logic                 seek_cmd_n,
  output logic                 read_cmd_n,
  output logic                 write_cmd_n,
  output logic      [0:15]     core_address
);
  import disk_host_pkg::*;

  localparam int NSYNC = 6 + 16 + 12 + UNITS + 4;

  logic [NSYNC-1:0] sync1, sync2, next_sync1, next_sync2;
  logic [11:0]      strb_d, next_strb_d;
  logic [5:0]  s_code;
  logic [0:15] s_data;
  logic s_doa, s_dob, s_doc, s_dia, s_dib, s_dic, s_pls, s_start_function, s_msk, s_ack, s_pri, s_sel;
  logic [UNITS-1:0] s_seek;
  logic s_rdy, s_err, s_done;

  // pins pass two flops before use; stage 1 feeds stage 2 only
  always_comb begin
    next_sync1 = {device_code_in, data_bus_in, data_out_a, data_out_b, data_out_c,
                  data_in_a, data_in_b, data_in_c, pulse_function, start_function,
                  mask_out, interrupt_acknowledge, priority_chain_in, adapter_selected,
                  seek_done_in, drive_ready, error_event, done_event, 1'b0};
    next_sync2 = sync1;
  end
  assign {s_code, s_data, s_doa, s_dob, s_doc, s_dia, s_dib, s_dic, s_pls, s_start_function,
          s_msk, s_ack, s_pri, s_sel, s_seek, s_rdy, s_err, s_done} = sync2[NSYNC-1:1];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  // instruction gating; data-out, pulse, start, mask and grant strobes act once, on their rising edge; reads follow the level
  logic        device_code_match;
  logic [11:0] strb_now, strb_rise;
  logic sel_doa, sel_dob, sel_doc, selected_pulse, sel_start_function, sel_msk, grant_rise;
  assign device_code_match = (s_code == DEVICE_CODE);
  assign strb_now  = {s_doa, s_dob, s_doc, s_dia, s_dib, s_dic, s_pls, s_start_function,
                      s_msk, s_ack, s_pri, s_sel};
  assign strb_rise = strb_now & ~strb_d;
  assign sel_doa        = device_code_match & strb_rise[11];
  assign sel_dob        = device_code_match & strb_rise[10];
  assign sel_doc        = device_code_match & strb_rise[9];
  assign selected_pulse = device_code_match & strb_rise[5];
  assign sel_start_function       = device_code_match & strb_rise[4];
  assign sel_msk        = strb_rise[3];     // mask-out is broadcast to all devices
  assign grant_rise     = strb_rise[0];
  always_comb next_strb_d = strb_now;

  // register, flag and pulse state
  logic [9:0]       cylinder_and_command, next_cyl;
  logic [15:0]      unit_sector_reg, next_usr;
  logic [0:15]      next_core;
  logic             start_ff, next_start, done_ff, next_done, err_ff, next_err;
  logic             int_disable, next_int_disable, next_pulse;
  logic [UNITS-1:0] seek_flag, next_seek, seek_d, next_seek_d;

  // seek-done edges set flags; a set in the clear cycle wins
  always_comb begin
    next_cyl         = cylinder_and_command;
    next_usr         = unit_sector_reg;
    next_core        = core_address;
    next_start       = start_ff;
    next_done        = done_ff;
    next_err         = err_ff;
    next_int_disable = int_disable;
    next_seek        = seek_flag;
    next_seek_d      = s_seek;
    next_pulse       = start_ff & grant_rise;
    if (sel_doc)
      next_usr = s_data;
    if (sel_doa) begin
      next_cyl = s_data[CYL_CMD_LO_BIT:15];
      if (s_data[CLR_ERR_DONE_BIT]) begin
        next_err  = 1'b0;
        next_done = 1'b0;
      end
      for (int u = 0; u < UNITS; u++)
        if (s_data[CLR_SEEK_LO_BIT + u])
          next_seek[u] = 1'b0;
    end
    if (sel_dob)
      next_core = s_data;
    if (sel_msk)
      next_int_disable = s_data[MASK_DISABLE_BIT];
    if (start_ff & grant_rise)
      next_start = 1'b0;
    if (selected_pulse | sel_start_function)
      next_start = 1'b1;
    next_seek = next_seek | (s_seek & ~seek_d);
    if (s_err)
      next_err = 1'b1;
    if (s_done)
      next_done = 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      strb_d               <= '0;
      cylinder_and_command <= CYL_CMD_RESET;
      unit_sector_reg      <= REG_RESET;
      core_address         <= REG_RESET;
      start_ff             <= 1'b0;
      done_ff              <= 1'b0;
      err_ff               <= 1'b0;
      int_disable          <= 1'b0;
      seek_flag            <= '0;
      seek_d               <= '0;
      start_adapter_pulse  <= 1'b0;
    end else begin
      strb_d               <= next_strb_d;
      cylinder_and_command <= next_cyl;
      unit_sector_reg      <= next_usr;
      core_address         <= next_core;
      start_ff             <= next_start;
      done_ff              <= next_done;
      err_ff               <= next_err;
      int_disable          <= next_int_disable;
      seek_flag            <= next_seek;
      seek_d               <= next_seek_d;
      start_adapter_pulse  <= next_pulse;
    end
  end

  // command decode, registered so every output leaves a flop
  logic dec_recalibrate_cmd_n, dec_seek_n, dec_read_n, dec_write_n;
  cmd_decode u_cmd_decode (
    .command_bit_high  (cylinder_and_command[9]),
    .command_bit_low   (cylinder_and_command[8]),
    .recalibrate_cmd_n (dec_recalibrate_cmd_n),
    .seek_cmd_n        (dec_seek_n),
    .read_cmd_n        (dec_read_n),
    .write_cmd_n       (dec_write_n)
  );

  // output image: bus read mux, flags, request and interrupt
  logic        pending_request_flag, ack_hit, rd_any;
  logic [0:15] status_word, next_bus;
  logic        next_busy, next_doneo, next_interrupt_request_line, next_prio;
  assign pending_request_flag = ~int_disable & (done_ff | (|seek_flag));
  assign ack_hit = s_ack & s_pri & pending_request_flag;
  assign rd_any  = (device_code_match & (s_dia | s_dib | s_dic)) | ack_hit;
  // status: busy, done, error, ready, then seek-complete flags per unit
  always_comb begin
    status_word = '0;
    status_word[0] = start_ff;
    status_word[1] = done_ff;
    status_word[2] = err_ff;
    status_word[3] = s_rdy;
    for (int u = 0; u < UNITS; u++)
      status_word[4 + u] = seek_flag[u];
  end

  always_comb begin
    next_bus = '0;
    if (ack_hit)
      next_bus[10:15] = DEVICE_CODE;
    else if (device_code_match & s_dic)
      next_bus = unit_sector_reg;
    else if (device_code_match & s_dib)
      next_bus = core_address;
    else if (device_code_match & s_dia)
      next_bus = status_word;
    next_busy  = device_code_match & start_ff;
    next_doneo = device_code_match & done_ff;
    next_interrupt_request_line  = pending_request_flag;
    next_prio  = s_pri & ~pending_request_flag;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      data_bus_out           <= '0;
      data_bus_oe            <= '0;
      busy_flag_out          <= 1'b0;
      done_flag_out          <= 1'b0;
      interrupt_request_line <= 1'b0;
      priority_chain_out     <= 1'b0;
      start_request_n        <= 1'b1;
      recalibrate_cmd_n      <= 1'b1;
      seek_cmd_n             <= 1'b1;
      read_cmd_n             <= 1'b0;  // cleared command register decodes as read
      write_cmd_n            <= 1'b1;
    end else begin
      data_bus_out           <= next_bus;
      data_bus_oe            <= {16{rd_any}};
      busy_flag_out          <= next_busy;
      done_flag_out          <= next_doneo;
      interrupt_request_line <= next_interrupt_request_line;
      priority_chain_out     <= next_prio;
      start_request_n        <= ~next_start;
      recalibrate_cmd_n      <= dec_recalibrate_cmd_n;
      seek_cmd_n             <= dec_seek_n;
      read_cmd_n             <= dec_read_n;
      write_cmd_n            <= dec_write_n;
    end
  end

endmodule : disk_ctrl_host_io_port
`default_nettype wire

// ### dv/disk_port_monitor.sv
/*
  Pin-level checks on the disk host port.
  Assumes one clock, mclk, and reset_n synchronous, active low.
*/
`timescale 1ns/10ps
`default_nettype none
module disk_port_monitor #(
  parameter logic [5:0] DEVICE_CODE = disk_host_pkg::DEV_CODE_PRIMARY
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // host side
  input wire logic [5:0]  device_code_in,
  input wire logic        data_in_a,
  input wire logic        data_in_b,
  input wire logic        data_in_c,
  input wire logic        pulse_function,
  input wire logic        start_function,
  input wire logic        interrupt_acknowledge,
  input wire logic        priority_chain_in,
  input wire logic [0:15] data_bus_out,
  input wire logic [0:15] data_bus_oe,
  input wire logic        busy_flag_out,
  input wire logic        done_flag_out,
  input wire logic        interrupt_request_line,
  // adapter side
  input wire logic        adapter_selected,
  input wire logic        start_request_n,
  input wire logic        start_adapter_pulse,
  input wire logic        recalibrate_cmd_n,
  input wire logic        seek_cmd_n,
  input wire logic        read_cmd_n,
  input wire logic        write_cmd_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // decoder, bus drivers and busy/done flags
  a_cmd_one_cold: assert property (
    $countones({recalibrate_cmd_n, seek_cmd_n, read_cmd_n, write_cmd_n}) == 3)
    else $error("command lines not one-cold");
  a_bus_idle: assert property (
    (!(data_in_a || data_in_b || data_in_c || interrupt_acknowledge))[*6] |-> data_bus_oe == '0)
    else $error("bus driven with no read active");
  a_no_match_flags: assert property (
    (device_code_in != DEVICE_CODE)[*5] |-> !busy_flag_out && !done_flag_out)
    else $error("flags shown without code match");
  a_ack_code: assert property (
    (interrupt_acknowledge && priority_chain_in && interrupt_request_line)[*5]
    |-> data_bus_out[10:15] == DEVICE_CODE && data_bus_oe == 16'hFFFF)
    else $error("device code not returned on acknowledge");
  // start request and grant handshake; margins cover the two sync stages
  a_start_cause: assert property (
    $fell(start_request_n) |-> ($past(pulse_function, 2) || $past(start_function, 2))
    && $past(device_code_in, 2) == DEVICE_CODE)
    else $error("start request without selected pulse");
  a_grant_fires: assert property (
    $rose(adapter_selected) && !start_request_n |-> ##[1:5] start_adapter_pulse)
    else $error("grant did not fire start pulse");
  a_pulse_single: assert property (
    start_adapter_pulse |=> !start_adapter_pulse)
    else $error("start pulse longer than one cycle");
  a_grant_release: assert property (
    start_adapter_pulse && !pulse_function && !start_function |-> ##[1:2] start_request_n)
    else $error("start pulse did not clear request");
endmodule : disk_port_monitor

bind disk_ctrl_host_io_port disk_port_monitor #(.DEVICE_CODE(DEVICE_CODE)) u_mon (
  .mclk(mclk), .reset_n(reset_n), .device_code_in(device_code_in),
  .data_in_a(data_in_a), .data_in_b(data_in_b), .data_in_c(data_in_c),
  .pulse_function(pulse_function), .start_function(start_function),
  .interrupt_acknowledge(interrupt_acknowledge), .priority_chain_in(priority_chain_in),
  .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .busy_flag_out(busy_flag_out),
  .done_flag_out(done_flag_out), .interrupt_request_line(interrupt_request_line),
  .adapter_selected(adapter_selected), .start_request_n(start_request_n),
  .start_adapter_pulse(start_adapter_pulse), .recalibrate_cmd_n(recalibrate_cmd_n),
  .seek_cmd_n(seek_cmd_n), .read_cmd_n(read_cmd_n), .write_cmd_n(write_cmd_n));
`default_nettype wire

// ### dv/adapter_model.sv
/*
  Two-channel adapter seen from controller B: grants a start request.
  Assumes other_busy marks the A channel in use, driven by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module adapter_model #(
  parameter int GRANT_DELAY = 3
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic reset_n,
  // controller B and channel A state
  input  wire logic start_request_n,
  input  wire logic other_busy,
  output logic      adapter_selected,
  output logic      channel_a_sel
);
  int wait_cnt;

  // grant only while channel A is idle; the delay models a slow multiplexer
  always_ff @(posedge mclk) begin
    if (!reset_n || start_request_n) begin
      wait_cnt <= 0;
      adapter_selected <= 1'b0;
    end else if (!other_busy && !adapter_selected) begin
      wait_cnt <= wait_cnt + 1;
      adapter_selected <= (wait_cnt >= GRANT_DELAY);
    end
  end

  // multiplexer points at A while A is served, else at B
  assign channel_a_sel = other_busy && !adapter_selected;
endmodule : adapter_model
`default_nettype wire

// ### dv/tb.sv
/*
  Self-checking bench for the disk host port with an adapter model.
  Assumes the instruction pins are held six clocks, as the port expects.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import disk_host_pkg::*;
  typedef struct packed {
    logic [0:15] cyl_word;
    logic [3:0]  cmd_n;
    logic [0:15] unit_word;
  } row_t;
  // one row per command code: cylinder word, decoded lines, unit word
  localparam row_t ROWS [4] = '{'{16'h005A, 4'hD, 16'h15FD}, '{16'h01C3, 4'hE, 16'h6AFF},
                                '{16'h0281, 4'hB, 16'h2301}, '{16'h03FF, 4'h7, 16'h7F80}};
  // strobe masks: doa dob doc dia dib dic pulse start mask ack
  localparam logic [9:0] DOA = 10'h001, DOB = 10'h002, DOC = 10'h004, DIA = 10'h008;
  localparam logic [9:0] DIB = 10'h010, DIC = 10'h020, PLS = 10'h040, STR = 10'h080;
  localparam logic [9:0] MSK = 10'h100, ACK = 10'h200;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  code = DEV_CODE_PRIMARY;
  logic [9:0]  strb = '0;
  logic [0:15] din = '0;
  logic        other_busy = 1'b0;
  logic        ready = 1'b1;
  logic        pri_in = 1'b1;
  logic        err_ev = 1'b0;
  logic        done_ev = 1'b0;
  logic [3:0]  seek_done = '0;
  logic [0:15] dout, doe, core, rd, rd_oe;
  logic        busy, done, irq, sel, req_n, sap, rc_n, sk_n, rd_n, wr_n, rd_done, pri_out;
  int          miscompares = 0;
  int          checks = 0;

  always #10 mclk = ~mclk;

  disk_ctrl_host_io_port #(.DEVICE_CODE(DEV_CODE_PRIMARY), .UNITS(4)) dut (
    .mclk(mclk), .reset_n(reset_n), .device_code_in(code), .data_out_a(strb[0]),
    .data_out_b(strb[1]), .data_out_c(strb[2]), .data_in_a(strb[3]), .data_in_b(strb[4]),
    .data_in_c(strb[5]), .pulse_function(strb[6]), .start_function(strb[7]),
    .mask_out(strb[8]), .interrupt_acknowledge(strb[9]), .priority_chain_in(pri_in),
    .data_bus_in(din), .data_bus_out(dout), .data_bus_oe(doe), .busy_flag_out(busy),
    .done_flag_out(done), .interrupt_request_line(irq), .priority_chain_out(pri_out),
    .adapter_selected(sel), .seek_done_in(seek_done), .drive_ready(ready),
    .error_event(err_ev), .done_event(done_ev), .start_request_n(req_n),
    .start_adapter_pulse(sap), .recalibrate_cmd_n(rc_n), .seek_cmd_n(sk_n),
    .read_cmd_n(rd_n), .write_cmd_n(wr_n), .core_address(core));

  adapter_model #(.GRANT_DELAY(3)) partner (.mclk(mclk), .reset_n(reset_n),
    .start_request_n(req_n), .other_busy(other_busy), .adapter_selected(sel),
    .channel_a_sel());

  task automatic report_and_stop();
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  // one instruction: pins held six clocks, read data taken before release
  task automatic instr(input logic [9:0] s, input logic [0:15] w);
    din = w;
    strb = s;
    repeat (6) @(posedge mclk);
    #2 rd = dout;
    rd_oe = doe;
    rd_done = done;
    strb = '0;
    repeat (6) @(posedge mclk);
    #2;
  endtask : instr

  // bounded wait for the grant to drop the start request
  task automatic wait_release();
    for (int i = 0; i < 40 && req_n !== 1'b1; i++) begin
      @(posedge mclk);
      #2;
    end
    chk(req_n, 1'b1);
    if (req_n !== 1'b1) report_and_stop();
  endtask : wait_release

  initial begin
    repeat (6) @(posedge mclk);
    #2 reset_n = 1'b1;
    chk({doe, req_n, busy, done, irq, rc_n, sk_n, rd_n, wr_n}, 24'h00008D);
    foreach (ROWS[i]) begin
      instr(DOA, ROWS[i].cyl_word);
      chk({rc_n, sk_n, rd_n, wr_n}, ROWS[i].cmd_n);
      instr(DOC, ROWS[i].unit_word);
      instr(DIC, 16'h0000);
      chk({rd_oe, rd}, {16'hFFFF, ROWS[i].unit_word});
    end
    // a foreign device code must change nothing
    code = DEV_CODE_SECONDARY;
    instr(DOA | PLS, 16'h0281);
    chk({req_n, busy, rc_n, sk_n, rd_n, wr_n}, 6'h27);
    code = DEV_CODE_PRIMARY;
    // seek start held off while channel A is busy
    other_busy = 1'b1;
    instr(DOA | PLS, 16'h0281);
    chk({req_n, sk_n, sel}, 3'h0);
    instr(DIA, 16'h0000);
    chk({busy, rd}, {1'b1, 16'h9000});
    other_busy = 1'b0;
    wait_release();
    // seek complete interrupt, acknowledge, mask and clear
    seek_done[0] = 1'b1;
    instr(DIA, 16'h0000);
    chk({irq, rd}, {1'b1, 16'h1800});
    instr(ACK, 16'h0000);
    chk({rd[10:15], pri_out}, {DEV_CODE_PRIMARY, 1'b0});
    // without priority-in the acknowledge must not be answered
    pri_in = 1'b0;
    instr(ACK, 16'h0000);
    chk({rd_oe, rd}, 32'h0);
    pri_in = 1'b1;
    instr(MSK, 16'h0100);
    chk(irq, 1'b0);
    instr(MSK, 16'h0000);
    chk(irq, 1'b1);
    instr(DOA, 16'h4000);
    seek_done[0] = 1'b0;
    chk(irq, 1'b0);
    // done and error flags, cleared together by bit 0
    done_ev = 1'b1;
    err_ev = 1'b1;
    repeat (2) @(posedge mclk);
    #2 done_ev = 1'b0;
    err_ev = 1'b0;
    instr(DIA, 16'h0000);
    chk({rd_done, irq, rd}, {2'b11, 16'h7000});
    instr(DOA, 16'h8000);
    instr(DIA, 16'h0000);
    chk({irq, rd}, {1'b0, 16'h1000});
    // a drive that is not ready must show in the status word
    ready = 1'b0;
    instr(DIA, 16'h0000);
    chk({pri_out, rd}, {1'b1, 16'h0000});
    ready = 1'b1;
    // core address load with start, then read back
    other_busy = 1'b1;
    instr(DOB | STR, 16'h1234);
    chk({req_n, core}, {1'b0, 16'h1234});
    instr(DIB, 16'h0000);
    chk(rd, 16'h1234);
    other_busy = 1'b0;
    wait_release();
    // mid-run reset must clear a done flag that is already requesting
    done_ev = 1'b1;
    repeat (4) @(posedge mclk);
    #2 done_ev = 1'b0;
    chk(irq, 1'b1);
    reset_n = 1'b0;
    repeat (3) @(posedge mclk);
    #2 reset_n = 1'b1;
    repeat (2) @(posedge mclk);
    #2 chk({irq, done, req_n, doe}, {3'b001, 16'h0000});
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
